//--- bench/mabd_core_checker.sv
// Concurrent checks on the instruction sequencer's ports.
// Assumes the opcode of each instruction is on i_prog_data in the
// cycle where the previous instruction reports completion.
`default_nettype none
module mabd_core_checker
  import mabd_pkg::*;
(
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_srst,
  // Program and control inputs
  input wire logic [7:0]  i_prog_data,
  input wire mabd_flags_s i_saved_flags,
  input wire logic        i_watchdog_opt,
  // Core state
  input wire logic [11:0] o_pc,
  input wire logic        o_stop_mode,
  input wire logic        o_wait_mode,
  input wire mabd_flags_s o_flags,
  input wire logic        o_instr_done
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  logic        go;
  logic        taken;
  logic [11:0] span;
  logic [11:0] jr_tgt;

  // The first opcode after reset has no completion before it, so skip it
  assign go = o_instr_done & ~o_stop_mode & ~o_wait_mode;
  assign span = {8'h00, i_prog_data[7:4]};

  always_comb begin
    case (i_prog_data[2:1])
      2'h0:    taken = ~o_flags.zero;
      2'h1:    taken = ~o_flags.carry;
      2'h2:    taken = o_flags.zero;
      default: taken = o_flags.carry;
    endcase
    jr_tgt = o_pc + 12'h001;
    if (taken) begin
      jr_tgt = i_prog_data[3] ? o_pc - span : o_pc + span + 12'h001;
    end
  end

  sequence jr_fetch;
    go && !i_prog_data[0];
  endsequence
  // Undefined codes in the pointer/immediate group run as two-cycle nops
  sequence alu_fetch;
    go && i_prog_data[2:0] == 3'h7 &&
      (i_prog_data[4] ? !i_prog_data[7] : i_prog_data[7:5] < 3'h6);
  endsequence
  sequence incdec_fetch;
    go && i_prog_data[7:6] == 2'h2 && (i_prog_data[3:0] == 4'h9 ||
      (i_prog_data[2:0] == 3'h7 && !i_prog_data[4]));
  endsequence

  jr_timing_a: assert property (jr_fetch |-> ##2 o_instr_done)
    else $error("short jump not two cycles");
  jr_target_a: assert property (
    jr_fetch |-> ##2 o_pc == $past(jr_tgt, 2))
    else $error("short jump target wrong");
  jr_flags_a: assert property (
    jr_fetch |-> ##2 o_flags == $past(o_flags, 2))
    else $error("short jump changed flags");
  btb_zero_a: assert property (
    go && i_prog_data[3:0] == 4'h3 |->
      ##5 (o_instr_done && o_flags.zero == $past(o_flags.zero, 5)))
    else $error("bit test branch timing or zero wrong");
  bit_force_a: assert property (
    go && i_prog_data[3:0] == 4'hB |->
      ##4 (o_instr_done && o_flags == $past(o_flags, 4)))
    else $error("bit set or reset timing or flags wrong");
  alu_timing_a: assert property (alu_fetch |-> ##4 o_instr_done)
    else $error("alu op not four cycles");
  incdec_carry_a: assert property (
    incdec_fetch |-> ##4 o_flags.carry == $past(o_flags.carry, 4))
    else $error("inc or dec changed carry");
  ctrl_timing_a: assert property (
    go && i_prog_data[3:0] == 4'hD && i_prog_data[7:4] < 4'h5 |->
      ##2 o_instr_done)
    else $error("control op not two cycles");
  interrupt_return_flags_a: assert property (
    go && i_prog_data == 8'h2D |-> ##2 o_flags == $past(i_saved_flags, 2))
    else $error("interrupt return flags wrong");
  stop_sub_a: assert property (
    go && i_prog_data == 8'h3D && i_watchdog_opt |->
      ##2 (o_wait_mode && !o_stop_mode))
    else $error("stop not replaced by wait");
endmodule : mabd_core_checker

bind mabd_core mabd_core_checker i_mabd_core_checker (
  .i_clock(i_clock), .i_srst(i_srst), .i_prog_data(i_prog_data),
  .i_saved_flags(i_saved_flags), .i_watchdog_opt(i_watchdog_opt),
  .o_pc(o_pc), .o_stop_mode(o_stop_mode), .o_wait_mode(o_wait_mode),
  .o_flags(o_flags), .o_instr_done(o_instr_done)
);
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench for the instruction sequencer.
// Assumes a combinational program store; data memory is set up by clears.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic                 i_clock;
  logic                 i_srst;
  logic                 i_watchdog_opt;
  logic                 i_wake;
  logic [11:0]          i_return_addr;
  mabd_pkg::mabd_flags_s i_saved_flags;
  logic [11:0]          o_prog_addr;
  logic [11:0]          o_pc;
  logic                 o_ret;
  logic                 o_interrupt_return;
  logic                 o_stop_mode;
  logic                 o_wait_mode;
  logic [7:0]           o_acc;
  mabd_pkg::mabd_flags_s o_flags;
  logic                 o_instr_done;
  logic [7:0]           rom [4096];
  int                   n_errors;
  int                   total_checks;
  int                   n_ret;
  int                   n_interrupt_return;
  int                   cyc;

  mabd_core i_mabd_core (
    .i_clock(i_clock), .i_srst(i_srst), .i_prog_data(rom[o_prog_addr]),
    .o_prog_addr(o_prog_addr), .o_pc(o_pc), .i_return_addr(i_return_addr),
    .i_saved_flags(i_saved_flags), .i_watchdog_opt(i_watchdog_opt),
    .i_wake(i_wake), .o_ret(o_ret), .o_interrupt_return(o_interrupt_return),
    .o_stop_mode(o_stop_mode), .o_wait_mode(o_wait_mode), .o_acc(o_acc),
    .o_flags(o_flags), .o_instr_done(o_instr_done)
  );

  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    n_ret += int'(o_ret);
    n_interrupt_return += int'(o_interrupt_return);
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h expected %h", $time, s, e);
    end
  endtask : chk

  // Empty program space reads as no-operation
  task automatic rst;
    foreach (rom[j]) rom[j] = 8'h0D;
    n_ret = 0;
    n_interrupt_return = 0;
    i_srst = 1'b1;
    repeat (5) @(negedge i_clock);
    i_srst = 1'b0;
  endtask : rst

  task automatic ld(input int a, input logic [7:0] q[$]);
    foreach (q[j]) rom[a+j] = q[j];
  endtask : ld

  // Waits for the next completion, then checks pc, accumulator and flags
  task automatic st(input logic [11:0] p, input logic [7:0] a,
                    input logic [1:0] f);
    int k;
    k = 0;
    @(negedge i_clock);
    while (o_instr_done !== 1'b1 && k < 20) begin
      @(negedge i_clock);
      k++;
    end
    chk({2'b00, o_pc, o_acc, o_flags}, {2'b00, p, a, f});
    chk({12'h000, o_prog_addr}, {12'h000, p});
  endtask : st

  task automatic t_alu;
    rst();
    ld(0, '{8'h17, 8'hF0, 8'h17, 8'h20, 8'h57, 8'h10, 8'h77, 8'h11,
            8'h37, 8'h00});
    st(12'h002, 8'hF0, 2'h0);
    st(12'h004, 8'h10, 2'h1);
    st(12'h006, 8'h10, 2'h2);
    st(12'h008, 8'hFF, 2'h1);
    st(12'h00A, 8'h00, 2'h2);
    $display("alu immediate test done");
  endtask : t_alu

  task automatic t_inh;
    rst();
    ld(0, '{8'h5D, 8'h6D, 8'h7D, 8'h00, 8'h8D, 8'h00});
    st(12'h001, 8'hFF, 2'h0);
    st(12'h002, 8'hFE, 2'h1);
    st(12'h004, 8'hFC, 2'h1);
    st(12'h006, 8'h00, 2'h2);
    $display("accumulator test done");
  endtask : t_inh

  task automatic t_mem;
    rst();
    ld(0, '{8'h17, 8'hFF, 8'h17, 8'h01, 8'h9D, 8'h90, 8'h00, 8'h89, 8'h90,
            8'hA9, 8'h90, 8'h89, 8'hFF, 8'h09, 8'h90});
    // Y is walked down to FFh so the indirect form reaches the accumulator
    ld(15, '{8'h9D, 8'h81, 8'h00, 8'h65, 8'h6F});
    st(12'h002, 8'hFF, 2'h0);
    st(12'h004, 8'h00, 2'h3);
    st(12'h007, 8'h00, 2'h3);
    st(12'h009, 8'h00, 2'h1);
    st(12'h00B, 8'h00, 2'h3);
    st(12'h00D, 8'h01, 2'h1);
    st(12'h00F, 8'h01, 2'h0);
    st(12'h012, 8'h01, 2'h0);
    st(12'h013, 8'h01, 2'h0);
    st(12'h014, 8'h00, 2'h2);
    $display("data space test done");
  endtask : t_mem

  task automatic t_bit;
    rst();
    ld(0, '{8'h9D, 8'h01, 8'h00, 8'h9D, 8'h80, 8'h00, 8'h05, 8'h7B, 8'h01,
            8'h07, 8'h73, 8'h01, 8'h02});
    ld(14, '{8'h6B, 8'h01, 8'h73, 8'h01, 8'h02, 8'h07, 8'h63, 8'h01,
             8'h80});
    st(12'h003, 8'h00, 2'h0);
    st(12'h006, 8'h00, 2'h0);
    st(12'h007, 8'h00, 2'h0);
    st(12'h009, 8'h00, 2'h0);
    st(12'h00A, 8'h08, 2'h0);
    st(12'h00E, 8'h08, 2'h1);
    st(12'h010, 8'h08, 2'h1);
    st(12'h013, 8'h08, 2'h0);
    st(12'h014, 8'h08, 2'h0);
    st(12'hF96, 8'h08, 2'h0);
    $display("bit test done");
  endtask : t_bit

  task automatic t_jr;
    rst();
    ld(0, '{8'h20});
    ld(3, '{8'h04, 8'h06, 8'h12});
    ld(7, '{8'h17, 8'h00, 8'hF4});
    ld(14, '{8'h00});
    ld(25, '{8'h17, 8'hFF, 8'h17, 8'h01, 8'hFE});
    st(12'h003, 8'h00, 2'h0);
    st(12'h004, 8'h00, 2'h0);
    st(12'h005, 8'h00, 2'h0);
    st(12'h007, 8'h00, 2'h0);
    st(12'h009, 8'h00, 2'h2);
    st(12'h019, 8'h00, 2'h2);
    st(12'h01B, 8'hFF, 2'h0);
    st(12'h01D, 8'h00, 2'h3);
    st(12'h00E, 8'h00, 2'h3);
    st(12'h00F, 8'h00, 2'h3);
    $display("short jump test done");
  endtask : t_jr

  task automatic t_ctrl;
    rst();
    ld(0, '{8'h0D, 8'h1D});
    ld(64, '{8'h2D});
    st(12'h001, 8'h00, 2'h0);
    st(12'h040, 8'h00, 2'h0);
    st(12'h040, 8'h00, 2'h2);
    repeat (2) @(negedge i_clock);
    chk(24'(n_ret), 24'h000001);
    chk(24'(n_interrupt_return), 24'h000001);
    $display("control test done");
  endtask : t_ctrl

  task automatic t_halt;
    for (int wd = 0; wd < 2; wd++) begin
      i_watchdog_opt = wd[0];
      rst();
      ld(0, '{8'h0D, 8'h3D, 8'h4D});
      st(12'h001, 8'h00, 2'h0);
      st(12'h002, 8'h00, 2'h0);
      repeat (3) @(negedge i_clock);
      chk({22'h0, o_stop_mode, o_wait_mode}, wd[0] ? 24'h1 : 24'h2);
      for (int m = 0; m < 2; m++) begin
        i_wake = 1'b1;
        @(negedge i_clock);
        i_wake = 1'b0;
        st(12'h003 + 12'(m), 8'h00, 2'h0);
        chk({22'h0, o_stop_mode, o_wait_mode}, m ? 24'h0 : 24'h1);
      end
    end
    $display("halt test done");
  endtask : t_halt

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    i_srst = 1'b1;
    i_wake = 1'b0;
    i_watchdog_opt = 1'b0;
    i_return_addr = 12'h040;
    i_saved_flags = 2'h2;
    n_errors = 0;
    total_checks = 0;
    cyc = 0;
    t_alu();
    t_inh();
    t_mem();
    t_bit();
    t_jr();
    t_ctrl();
    t_halt();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire

//--- pkg/mabd_params.svh
// Constants for the 8-bit ALU, branch and control instruction sequencer.
// Assumes inclusion by mabd_core; defines only macros.
//
// Functional notes
// - Add, and, compare, subtract pair accumulator with memory or immediate.
// - Clear, decrement and increment may target any data-space location.
// - Complement, rotate-through-carry, shift-left act on accumulator only.
// - Short jumps branch on carry or zero set or clear, else fall through.
// - Short jumps are one byte, two cycles, span -15..+16, flags kept.
// - Bit-test branches are three bytes, five cycles, span -126..+129.
// - Bit-test branch copies tested bit into carry always, zero kept.
// - Three opcode bits select the bit used by bit test and set/reset.
// - Bit set/reset force one bit of any byte, two bytes, four cycles.
// - With watchdog option the stop opcode enters wait mode instead.
// - ALU ops take four cycles with listed zero/carry effects.
// - Lengths: indirect/inherent one, direct/immediate two, exceptions.
// - Nop, return, interrupt return, stop, wait: one byte, two cycles.
// - Indirect forms take the address from location 80h or 81h.
// - Short jump opcode holds test code, direction bit and four-bit span.
`ifndef MABD_PARAMS_SVH
`define MABD_PARAMS_SVH

// Data-space locations
`define MABD_PTR_X_LOC   8'h80
`define MABD_PTR_Y_LOC   8'h81
`define MABD_SHORT_BASE  6'h20
`define MABD_ACC_LOC     8'hFF

// Opcode low-nibble groups
`define MABD_LN_BTB      4'h3
`define MABD_LN_BSR      4'hB
`define MABD_LN3_IND     3'h7
`define MABD_LN_SD       4'h5
`define MABD_LN_DIR      4'h9
`define MABD_LN_INH      4'hD

// Short jump test codes
`define MABD_TST_NZ      3'h0
`define MABD_TST_NC      3'h2
`define MABD_TST_Z       3'h4
`define MABD_TST_C       3'h6

// Inherent high-nibble codes
`define MABD_INH_NOP     4'h0
`define MABD_INH_RET     4'h1
`define MABD_INH_INTERRUPT_RETURN    4'h2
`define MABD_INH_STOP    4'h3
`define MABD_INH_WAIT    4'h4
`define MABD_INH_COM     4'h5
`define MABD_INH_RLC     4'h6
`define MABD_INH_SLA     4'h7
`define MABD_INH_CLRA    4'h8
`define MABD_INH_CLRR    4'h9

// Cycle counts and byte lengths
`define MABD_CYC_CTRL    3'h2
`define MABD_CYC_ALU     3'h4
`define MABD_CYC_BTB     3'h5
`define MABD_LEN1        2'h1
`define MABD_LEN2        2'h2
`define MABD_LEN3        2'h3

`endif

//--- pkg/mabd_pkg.sv
// Types shared by the instruction sequencer, its checker and its bench.
// Assumes mabd_params.svh sits on the include path.
`default_nettype none
package mabd_pkg;
  typedef enum logic [1:0] {
    MABD_RUN  = 2'b01,
    MABD_HALT = 2'b10
  } mabd_state_e;

  typedef enum logic [3:0] {
    MABD_CL_NOP, MABD_CL_JR, MABD_CL_BTB, MABD_CL_BSR, MABD_CL_ALU,
    MABD_CL_RET, MABD_CL_INTERRUPT_RETURN, MABD_CL_STOP, MABD_CL_WAIT
  } mabd_class_e;

  typedef enum logic [3:0] {
    MABD_OP_ADD, MABD_OP_AND, MABD_OP_CP, MABD_OP_SUB, MABD_OP_INC,
    MABD_OP_DEC, MABD_OP_CLR, MABD_OP_CLRA, MABD_OP_COM, MABD_OP_RLC,
    MABD_OP_SLA, MABD_OP_NONE
  } mabd_alu_e;

  typedef enum logic [2:0] {
    MABD_M_INH, MABD_M_IND, MABD_M_DIR, MABD_M_IMM, MABD_M_SD
  } mabd_mode_e;

  typedef struct packed {
    logic zero;
    logic carry;
  } mabd_flags_s;

  typedef struct packed {
    mabd_class_e cls;
    mabd_alu_e   alu;
    mabd_mode_e  mode;
    logic [1:0]  len;
    logic [2:0]  cycles;
    logic        upd_z;
    logic        upd_c;
  } mabd_dec_s;
endpackage : mabd_pkg
`default_nettype wire

//--- rtl/mabd_core.sv
// Sequencer for the arithmetic/logic, branch, bit and control groups.
// Assumes program memory answers o_prog_addr in the same cycle and that
// the stack and mode controllers outside act on the return/mode outputs.
`default_nettype none
`include "mabd_params.svh"
module mabd_core
  import mabd_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  // Program space
  input  wire logic [7:0]  i_prog_data,
  output logic      [11:0] o_prog_addr,
  output logic      [11:0] o_pc,
  // Stack and mode control
  input  wire logic [11:0] i_return_addr,
  input  wire mabd_flags_s i_saved_flags,
  input  wire logic        i_watchdog_opt,
  input  wire logic        i_wake,
  output logic             o_ret,
  output logic             o_interrupt_return,
  output logic             o_stop_mode,
  output logic             o_wait_mode,
  // Core state
  output logic      [7:0]  o_acc,
  output mabd_flags_s      o_flags,
  output logic             o_instr_done
);
  mabd_state_e state_r, state_nxt;
  logic [11:0] pc_r, pc_nxt, fetch_r, fetch_nxt;
  logic [2:0]  cyc_r, cyc_nxt;
  logic [7:0]  op_r, op_nxt, b2_r, b2_nxt, b3_r, b3_nxt;
  logic [7:0]  addr_r, addr_nxt, acc_r, acc_nxt;
  mabd_flags_s flags_r, flags_nxt;
  logic done_r, done_nxt, ret_r, ret_nxt, interrupt_return_r, interrupt_return_nxt;
  logic stop_r, stop_nxt, wait_r, wait_nxt;
  logic [7:0]  rd_addr, rd_data, wr_data, opnd, res;
  logic        wr_en, cout;
  logic [7:0]  op;
  mabd_dec_s   dec;
  logic        last;

  function automatic mabd_alu_e alu_sel(input logic [2:0] code);
    case (code)
      3'h0:    return MABD_OP_ADD;
      3'h1:    return MABD_OP_AND;
      3'h2:    return MABD_OP_CP;
      3'h3:    return MABD_OP_SUB;
      3'h4:    return MABD_OP_INC;
      3'h5:    return MABD_OP_DEC;
      default: return MABD_OP_NONE;
    endcase
  endfunction : alu_sel

  function automatic mabd_dec_s decode(input logic [7:0] o);
    mabd_dec_s d;
    d = '{MABD_CL_NOP, MABD_OP_NONE, MABD_M_INH, `MABD_LEN1,
          `MABD_CYC_CTRL, 1'b0, 1'b0};
    if (!o[0]) begin
      d.cls = MABD_CL_JR;
    end else if (o[3:0] == `MABD_LN_BTB) begin
      d.cls = MABD_CL_BTB;
      d.mode = MABD_M_DIR;
      d.len = `MABD_LEN3;
      d.cycles = `MABD_CYC_BTB;
      d.upd_c = 1'b1;
    end else if (o[3:0] == `MABD_LN_BSR) begin
      d.cls = MABD_CL_BSR;
      d.mode = MABD_M_DIR;
      d.len = `MABD_LEN2;
      d.cycles = `MABD_CYC_ALU;
    end else if (o[2:0] == `MABD_LN3_IND) begin
      d.alu = alu_sel(o[7:5]);
      d.mode = o[4] ? MABD_M_IMM : MABD_M_IND;
      d.len = o[4] ? `MABD_LEN2 : `MABD_LEN1;
      if (o[4] && o[7]) begin
        d.alu = MABD_OP_NONE;
      end
    end else if (o[3:0] == `MABD_LN_SD && !o[4]) begin
      d.alu = o[5] ? MABD_OP_DEC : MABD_OP_INC;
      d.mode = MABD_M_SD;
    end else if (o[3:0] == `MABD_LN_DIR) begin
      d.alu = alu_sel(o[7:5]);
      d.mode = MABD_M_DIR;
      d.len = `MABD_LEN2;
    end else if (o[3:0] == `MABD_LN_INH) begin
      case (o[7:4])
        `MABD_INH_RET:  d.cls = MABD_CL_RET;
        `MABD_INH_INTERRUPT_RETURN: d.cls = MABD_CL_INTERRUPT_RETURN;
        `MABD_INH_STOP: d.cls = MABD_CL_STOP;
        `MABD_INH_WAIT: d.cls = MABD_CL_WAIT;
        `MABD_INH_COM:  d.alu = MABD_OP_COM;
        `MABD_INH_RLC:  d.alu = MABD_OP_RLC;
        `MABD_INH_SLA: begin
          d.alu = MABD_OP_SLA;
          d.len = `MABD_LEN2;
        end
        `MABD_INH_CLRA: begin
          d.alu = MABD_OP_CLRA;
          d.len = `MABD_LEN2;
        end
        `MABD_INH_CLRR: begin
          d.alu = MABD_OP_CLR;
          d.mode = MABD_M_DIR;
          d.len = `MABD_LEN3;
        end
        default: d.cls = MABD_CL_NOP;
      endcase
    end
    if (d.alu != MABD_OP_NONE) begin
      d.cls = MABD_CL_ALU;
      d.cycles = `MABD_CYC_ALU;
      d.upd_z = (d.alu != MABD_OP_CLR);
      d.upd_c = !(d.alu inside {MABD_OP_CLR, MABD_OP_INC, MABD_OP_DEC});
    end
    return d;
  endfunction : decode

  assign op   = (cyc_r == 3'h0) ? i_prog_data : op_r;
  assign dec  = decode(op);
  assign last = (cyc_r == dec.cycles - 3'h1) && (state_r == MABD_RUN);

  // Pointer fetch first, then the byte it points at
  always_comb begin
    if (cyc_r == 3'h1) begin
      if (dec.mode == MABD_M_IND) begin
        rd_addr = op[3] ? `MABD_PTR_Y_LOC : `MABD_PTR_X_LOC;
      end else if (dec.mode == MABD_M_SD) begin
        rd_addr = {`MABD_SHORT_BASE, op[7:6]};
      end else begin
        rd_addr = i_prog_data;
      end
    end else if (cyc_r == 3'h2 && dec.mode == MABD_M_IND) begin
      rd_addr = rd_data;
    end else begin
      rd_addr = addr_r;
    end
  end

  // The accumulator is also visible as a data-space location
  always_comb begin
    if (dec.mode == MABD_M_IMM) begin
      opnd = b2_r;
    end else if (addr_r == `MABD_ACC_LOC) begin
      opnd = acc_r;
    end else begin
      opnd = rd_data;
    end
    cout = flags_r.carry;
    res = acc_r;
    case (dec.alu)
      MABD_OP_ADD:  {cout, res} = {1'b0, acc_r} + {1'b0, opnd};
      MABD_OP_AND: begin
        res = acc_r & opnd;
        cout = 1'b0;
      end
      MABD_OP_CP,
      MABD_OP_SUB:  {cout, res} = {1'b0, acc_r} - {1'b0, opnd};
      MABD_OP_INC:  res = opnd + 8'h01;
      MABD_OP_DEC:  res = opnd - 8'h01;
      MABD_OP_CLR,
      MABD_OP_CLRA: begin
        res = 8'h00;
        cout = 1'b0;
      end
      MABD_OP_COM: begin
        res = ~acc_r;
        cout = acc_r[7];
      end
      MABD_OP_RLC:  {cout, res} = {acc_r, flags_r.carry};
      MABD_OP_SLA:  {cout, res} = {acc_r, 1'b0};
      default:      res = acc_r;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    pc_nxt    = pc_r;
    fetch_nxt = fetch_r;
    cyc_nxt   = cyc_r;
    op_nxt    = op_r;
    b2_nxt    = b2_r;
    b3_nxt    = b3_r;
    addr_nxt  = addr_r;
    acc_nxt   = acc_r;
    flags_nxt = flags_r;
    done_nxt  = 1'b0;
    ret_nxt   = 1'b0;
    interrupt_return_nxt  = 1'b0;
    stop_nxt  = stop_r;
    wait_nxt  = wait_r;
    wr_en     = 1'b0;
    wr_data   = res;
    case (state_r)
      MABD_HALT: begin
        if (i_wake) begin
          state_nxt = MABD_RUN;
          stop_nxt  = 1'b0;
          wait_nxt  = 1'b0;
        end
      end
      default: begin
        cyc_nxt = cyc_r + 3'h1;
        if (cyc_r < 3'h2) begin
          fetch_nxt = fetch_r + 12'h001;
        end
        if (cyc_r == 3'h0) begin
          op_nxt = i_prog_data;
        end
        if (cyc_r == 3'h1) begin
          b2_nxt = i_prog_data;
          addr_nxt = rd_addr;
        end
        if (cyc_r == 3'h2) begin
          b3_nxt = i_prog_data;
          if (dec.mode == MABD_M_IND) begin
            addr_nxt = rd_data;
          end
        end
        if (last) begin
          cyc_nxt  = 3'h0;
          done_nxt = 1'b1;
          pc_nxt   = pc_r + {10'h000, dec.len};
          case (dec.cls)
            MABD_CL_JR: begin
              if ((op[2:0] == `MABD_TST_C  &&  flags_r.carry) ||
                  (op[2:0] == `MABD_TST_NC && !flags_r.carry) ||
                  (op[2:0] == `MABD_TST_Z  &&  flags_r.zero)  ||
                  (op[2:0] == `MABD_TST_NZ && !flags_r.zero)) begin
                pc_nxt = op[3] ? pc_r - {8'h00, op[7:4]}
                               : pc_r + {8'h00, op[7:4]} + 12'h001;
              end
            end
            MABD_CL_BTB: begin
              flags_nxt.carry = opnd[op[7:5]];
              if (opnd[op[7:5]] == op[4]) begin
                pc_nxt = pc_r + 12'h002 + {{4{b3_r[7]}}, b3_r};
              end
            end
            MABD_CL_BSR: begin
              wr_data = opnd;
              wr_data[op[7:5]] = op[4];
              wr_en = 1'b1;
            end
            MABD_CL_ALU: begin
              if (dec.upd_z) begin
                flags_nxt.zero = (res == 8'h00);
              end
              if (dec.upd_c) begin
                flags_nxt.carry = cout;
              end
              if (dec.alu inside {MABD_OP_INC, MABD_OP_DEC, MABD_OP_CLR}) begin
                wr_en = 1'b1;
              end else if (dec.alu != MABD_OP_CP) begin
                acc_nxt = res;
              end
            end
            MABD_CL_RET: begin
              pc_nxt  = i_return_addr;
              ret_nxt = 1'b1;
            end
            MABD_CL_INTERRUPT_RETURN: begin
              pc_nxt    = i_return_addr;
              flags_nxt = i_saved_flags;
              interrupt_return_nxt  = 1'b1;
            end
            MABD_CL_STOP,
            MABD_CL_WAIT: begin
              state_nxt = MABD_HALT;
              if (dec.cls == MABD_CL_STOP && !i_watchdog_opt) begin
                stop_nxt = 1'b1;
              end else begin
                wait_nxt = 1'b1;
              end
            end
            default: pc_nxt = pc_r + {10'h000, dec.len};
          endcase
          fetch_nxt = pc_nxt;
          // Writes aimed at the accumulator location land in the register
          if (wr_en && addr_r == `MABD_ACC_LOC) begin
            acc_nxt = wr_data;
            wr_en = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_r <= MABD_RUN;
      pc_r    <= 12'h000;
      fetch_r <= 12'h000;
      cyc_r   <= 3'h0;
      op_r    <= 8'h00;
      b2_r    <= 8'h00;
      b3_r    <= 8'h00;
      addr_r  <= 8'h00;
      acc_r   <= 8'h00;
      flags_r <= '0;
      done_r  <= 1'b0;
      ret_r   <= 1'b0;
      interrupt_return_r  <= 1'b0;
      stop_r  <= 1'b0;
      wait_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
      fetch_r <= fetch_nxt;
      cyc_r   <= cyc_nxt;
      op_r    <= op_nxt;
      b2_r    <= b2_nxt;
      b3_r    <= b3_nxt;
      addr_r  <= addr_nxt;
      acc_r   <= acc_nxt;
      flags_r <= flags_nxt;
      done_r  <= done_nxt;
      ret_r   <= ret_nxt;
      interrupt_return_r  <= interrupt_return_nxt;
      stop_r  <= stop_nxt;
      wait_r  <= wait_nxt;
    end
  end

  mabd_dmem #(
    .AW (8),
    .DW (8)
  ) u_dmem (
    .i_clock   (i_clock),
    .i_srst    (i_srst),
    .i_wr_en   (wr_en),
    .i_wr_addr (addr_r),
    .i_wr_data (wr_data),
    .i_rd_addr (rd_addr),
    .o_rd_data (rd_data)
  );

  assign o_prog_addr  = fetch_r;
  assign o_pc         = pc_r;
  assign o_acc        = acc_r;
  assign o_flags      = flags_r;
  assign o_instr_done = done_r;
  assign o_ret        = ret_r;
  assign o_interrupt_return       = interrupt_return_r;
  assign o_stop_mode  = stop_r;
  assign o_wait_mode  = wait_r;
endmodule : mabd_core
`default_nettype wire

//--- rtl/mabd_dmem.sv
// 256-byte data space store with one write and one registered read port.
// Assumes a single clock; write and read of one address in one cycle
// returns the old byte.
`default_nettype none
module mabd_dmem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          i_clock,
  input  wire logic          i_srst,
  // Write port
  input  wire logic          i_wr_en,
  input  wire logic [AW-1:0] i_wr_addr,
  input  wire logic [DW-1:0] i_wr_data,
  // Read port
  input  wire logic [AW-1:0] i_rd_addr,
  output logic      [DW-1:0] o_rd_data
);
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] rd_data_r;

  always_ff @(posedge i_clock) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= mem[i_rd_addr];
    end
  end

  assign o_rd_data = rd_data_r;
endmodule : mabd_dmem
`default_nettype wire
